// *** chan_pkg.sv ***
// shared constants for the channel command/condition byte link
package chan_pkg;
  // ==========================================================
  // sizes
  localparam int CH_N   = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int REG_AW = 6;
  localparam int REG_N  = 64;
  localparam int CMD_W  = CH_N * BYTE_W;
  localparam int DAT_W  = CH_N * WORD_W;
  // ==========================================================
  // command and condition byte fields
  localparam int MODE_BIT = 7;
  localparam int DIR_BIT  = 6;
  localparam int ERR_BIT  = 6;
  localparam int NUM_MSB  = 5;
  localparam int LIM2_LSB = 4;
  localparam int LIM1_LSB = 2;
  localparam int OVR_BIT  = 1;
  localparam int UND_BIT  = 0;
  typedef enum logic [1:0] {
    LIM_OFF   = 2'b00,
    LIM_BELOW = 2'b01,
    LIM_ABOVE = 2'b10,
    LIM_EQUAL = 2'b11
  } limit_state_type;
  // ==========================================================
  // per-channel parameter registers
  localparam logic [REG_AW-1:0] REG_RAW     = 6'h00;
  localparam logic [REG_AW-1:0] REG_DIAG    = 6'h06;
  localparam logic [REG_AW-1:0] REG_RO_LO   = 6'h08;
  localparam logic [REG_AW-1:0] REG_RO_HI   = 6'h0d;
  localparam logic [REG_AW-1:0] REG_OVR_LIM = 6'h15;
  localparam logic [REG_AW-1:0] REG_UND_LIM = 6'h16;
  localparam logic [REG_AW-1:0] REG_FEATURE = 6'h20;
  localparam logic [REG_AW-1:0] REG_LIM1    = 6'h23;
  localparam logic [REG_AW-1:0] REG_LIM2    = 6'h24;
  localparam logic [WORD_W-1:0] OVR_RST     = 16'h0fff;
  localparam logic [WORD_W-1:0] FEATURE_RST = 16'h0906;
  localparam int FEAT_LIM1_BIT = 14;
  localparam int FEAT_LIM2_BIT = 15;
  // ==========================================================
  // controller register map (apb byte addresses)
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_CMD    = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_OUT_LO = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_OUT_HI = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_STAT   = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_IN_LO  = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_IN_HI  = 8'h18;
  localparam logic [APB_AW-1:0] ADDR_FLAGS  = 8'h1c;
  localparam int CTRL_CYCLIC_BIT = 0;
  localparam int CTRL_START_BIT  = 1;
  localparam int FLAG_BUSY_BIT   = 0;
  localparam int FLAG_DONE_BIT   = 1;
  localparam int FLAG_ACK_LSB    = 2;
  // ==========================================================
  // controller exchange sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b11
  } xchg_state_type;
endpackage

// *** chan_link_if.sv ***
// process image link between controller and terminal
`timescale 1ns/1ps
interface chan_link_if import chan_pkg::*; ();
  logic             req;  // exchange request pulse
  logic [CMD_W-1:0] cmd;  // command bytes, channel 1 low
  logic [DAT_W-1:0] dout; // output data words
  logic             resp; // exchange answer pulse
  logic [CMD_W-1:0] stat; // condition bytes
  logic [DAT_W-1:0] din;  // input data words
  modport controller (output req, cmd, dout, input resp, stat, din);
  modport terminal (input req, cmd, dout, output resp, stat, din);
endinterface

// *** terminal_end.sv ***
// terminal end: per-channel command decode and condition bytes
// ==========================================================
// Summary of operation
// - command bit 7 set selects register mode
// - bit 7 clear gives process data mode
// - process mode ignores command bits 6..0
// - process mode returns condition bit 7 low
// - bits 5:4 show second threshold comparison
// - bits 3:2 show first threshold comparison
// - bit 1 flags value above range
// - bit 0 flags value below range
// - controller puts direction and register number
// - register mode echoes register number handled
// - four channels with identical byte pairs
// - controller sends command bytes every exchange
// - terminal returns condition bytes every exchange
// - data word is low and high byte
`timescale 1ns/1ps
module terminal_end import chan_pkg::*; (
  // clock, reset, enable
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // measured values, channel 1 in the low word
  input  wire logic [DAT_W-1:0] i_sample,
  // link to the controller
  chan_link_if.terminal         lnk,
  // per-channel register mode indication
  output logic      [CH_N-1:0]  o_reg_mode
);

  // ==========================================================
  // helpers
  // threshold comparison coding
  // disabled threshold reports off, whatever the value
  // unsigned compare; equal only on an exact match
  // enable bits sit in the feature register of the channel
  function automatic limit_state_type cmp_limit(
    input logic              en,
    input logic [WORD_W-1:0] val,
    input logic [WORD_W-1:0] lim
  );
    limit_state_type r;
    r = LIM_OFF;
    if (en) begin
      if (val < lim) begin
        r = LIM_BELOW;
      end else if (val > lim) begin
        r = LIM_ABOVE;
      end else begin
        r = LIM_EQUAL;
      end
    end
    return r;
  endfunction

  // registers that accept writes
  // raw value and diagnostic are computed, not stored
  // identification block stays read only
  // a refused write is still echoed, so software must
  // read the register back to see whether it took
  function automatic logic wr_ok(input logic [REG_AW-1:0] n);
    logic ok;
    ok = 1'b1;
    if (n == REG_RAW || n == REG_DIAG) begin
      ok = 1'b0;
    end
    if (n >= REG_RO_LO && n <= REG_RO_HI) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // ==========================================================
  // answer strobe
  // fixed turnaround: answer one cycle after each request
  // condition bytes and words change on that edge only
  // and hold until the next request, so the controller
  // never captures a half updated image
  // with the enable low the request is simply not seen yet
  // and the controller, sharing the enable, waits as well
  logic resp_r;

  // one answer per request
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      resp_r <= 1'b0;
    end else if (i_ce) begin
      resp_r <= lnk.req;
    end
  end

  assign lnk.resp = resp_r;

  // ==========================================================
  // channels
  // one slice per channel, all built alike
  // command byte c and word c of the image belong to slice c
  // each slice keeps its own parameter store, so writes to
  // one channel never touch the limits of another
  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    // link fields of this channel
    // direction and number matter only in register mode
    // process mode ignores bits 6..0 altogether
    wire logic [BYTE_W-1:0] cmd;
    wire logic [WORD_W-1:0] wout;
    wire logic [WORD_W-1:0] smp;
    wire logic              sel_reg;
    wire logic              is_wr;
    wire logic [REG_AW-1:0] num;

    assign cmd     = lnk.cmd[c*BYTE_W +: BYTE_W];
    assign wout    = lnk.dout[c*WORD_W +: WORD_W];
    assign smp     = i_sample[c*WORD_W +: WORD_W];
    assign sel_reg = cmd[MODE_BIT];
    assign is_wr   = cmd[DIR_BIT];
    assign num     = cmd[NUM_MSB:0];

    // parameter store of this channel
    // kept in flops so that reset can preset the limits
    // a block ram would save area but lose the preset
    logic [WORD_W-1:0] mem [REG_N];

    // process data evaluation
    // flags follow the sample continuously; only the copy
    // taken at a request is returned
    // error is the or of the range flags
    wire logic              ovr;
    wire logic              und;
    wire logic              err;
    wire limit_state_type   lim1;
    wire limit_state_type   lim2;
    wire logic [BYTE_W-1:0] pd_stat;
    wire logic [BYTE_W-1:0] rc_stat;
    wire logic [WORD_W-1:0] rd_word;
    wire logic [BYTE_W-1:0] stat_nxt;
    wire logic [WORD_W-1:0] word_nxt;
    wire logic              do_wr;

    assign ovr  = smp > mem[REG_OVR_LIM];
    assign und  = smp < mem[REG_UND_LIM];
    assign err  = ovr | und;
    assign lim1 = cmp_limit(mem[REG_FEATURE][FEAT_LIM1_BIT],
                            smp, mem[REG_LIM1]);
    assign lim2 = cmp_limit(mem[REG_FEATURE][FEAT_LIM2_BIT],
                            smp, mem[REG_LIM2]);

    // condition byte in process data mode, command bits unused
    assign pd_stat = {1'b0, err, lim2, lim1, ovr, und};

    // condition byte in register mode echoes what was handled
    assign rc_stat = {1'b1, is_wr, num};

    // register read source
    // raw value and diagnostic come from live logic
    assign rd_word = (num == REG_RAW)  ? smp :
                     (num == REG_DIAG) ? {{BYTE_W{1'b0}}, pd_stat} :
                     mem[num];

    // mode bit picks byte and word; a write returns the
    // word that was offered, a read the register contents
    // process mode returns the sample itself
    assign stat_nxt = sel_reg ? rc_stat : pd_stat;
    assign word_nxt = !sel_reg ? smp : (is_wr ? wout : rd_word);
    assign do_wr    = lnk.req & sel_reg & is_wr & wr_ok(num);

    // parameter store, written only by register mode writes
    // a write lands at the request edge, and the same
    // exchange answers with the word that was written
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        for (int i = 0; i < REG_N; i++) begin
          mem[i] <= '0;
        end
        mem[REG_OVR_LIM] <= OVR_RST;
        mem[REG_FEATURE] <= FEATURE_RST;
      end else if (i_ce && do_wr) begin
        mem[num] <= wout;
      end
    end

    // returned byte, word and mode flag
    // all three move together at the request edge
    // mode flag mirrors the top bit of the condition byte
    logic [BYTE_W-1:0] stat_r;
    logic [WORD_W-1:0] word_r;
    logic              mode_r;

    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        stat_r <= '0;
        word_r <= '0;
        mode_r <= 1'b0;
      end else if (i_ce && lnk.req) begin
        stat_r <= stat_nxt;
        word_r <= word_nxt;
        mode_r <= sel_reg;
      end
    end

    assign lnk.stat[c*BYTE_W +: BYTE_W] = stat_r;
    assign lnk.din[c*WORD_W +: WORD_W]  = word_r;
    assign o_reg_mode[c]                = mode_r;
  end

  // the answer strobe is shared by all slices
  // because all channels travel in one image

endmodule // terminal_end

// *** controller_end.sv ***
// controller end: apb registers driving the process image exchange
`timescale 1ns/1ps
module controller_end import chan_pkg::*; (
  // clock, reset, enable
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // link to the terminal
  chan_link_if.controller        lnk
);

  // ==========================================================
  // registers
  logic             cyclic_r;
  logic [CMD_W-1:0] cmd_r;
  logic [DAT_W-1:0] out_r;
  logic [CMD_W-1:0] cmd_l_r;
  logic [DAT_W-1:0] out_l_r;
  logic [CMD_W-1:0] stat_r;
  logic [DAT_W-1:0] in_r;
  logic             done_r;
  logic [CH_N-1:0]  ack_r;
  logic             req_r;
  xchg_state_type   st_r;
  xchg_state_type   st_nxt;

  // ==========================================================
  // apb decode
  wire logic        acc;
  wire logic        wr;
  wire logic        start;
  wire logic        capture;
  wire logic        mapped;
  wire logic        clr_done;
  wire logic [31:0] rd_mux;
  wire logic [CH_N-1:0] ack_nxt;

  assign acc      = i_psel & i_penable & ~o_pready;
  // writes land at the edge that completes the access
  assign wr       = i_psel & i_penable & o_pready & i_pwrite;
  assign mapped   = i_paddr <= ADDR_FLAGS && i_paddr[1:0] == 2'b00;
  assign start    = (wr && i_paddr == ADDR_CTRL &&
                     i_pwdata[CTRL_START_BIT]) || cyclic_r;
  assign capture  = st_r == ST_WAIT && lnk.resp;
  assign clr_done = wr && i_paddr == ADDR_FLAGS &&
                    i_pwdata[FLAG_DONE_BIT];
  assign rd_mux =
    (i_paddr == ADDR_CTRL)   ? {31'h0, cyclic_r} :
    (i_paddr == ADDR_CMD)    ? cmd_r :
    (i_paddr == ADDR_OUT_LO) ? out_r[31:0] :
    (i_paddr == ADDR_OUT_HI) ? out_r[63:32] :
    (i_paddr == ADDR_STAT)   ? stat_r :
    (i_paddr == ADDR_IN_LO)  ? in_r[31:0] :
    (i_paddr == ADDR_IN_HI)  ? in_r[63:32] :
    (i_paddr == ADDR_FLAGS)  ? {26'h0, ack_r, done_r,
                                st_r != ST_IDLE} :
    32'h0;

  // echo check: mode bit, and number when in register mode
  for (genvar c = 0; c < CH_N; c++) begin : g_ack
    wire logic [BYTE_W-1:0] sb;
    wire logic [BYTE_W-1:0] cb;
    assign sb = lnk.stat[c*BYTE_W +: BYTE_W];
    assign cb = cmd_l_r[c*BYTE_W +: BYTE_W];
    assign ack_nxt[c] = sb[MODE_BIT] == cb[MODE_BIT] &&
      (!cb[MODE_BIT] || sb[NUM_MSB:0] == cb[NUM_MSB:0]);
  end

  // apb answer, one wait state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready  <= acc;
      o_prdata  <= (acc && !i_pwrite) ? rd_mux : '0;
      o_pslverr <= acc & ~mapped;
    end
  end

  // software registers
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cyclic_r <= 1'b0;
      cmd_r    <= '0;
      out_r    <= '0;
    end else if (i_ce && wr) begin
      case (i_paddr)
        ADDR_CTRL:   cyclic_r      <= i_pwdata[CTRL_CYCLIC_BIT];
        ADDR_CMD:    cmd_r         <= i_pwdata;
        ADDR_OUT_LO: out_r[31:0]   <= i_pwdata;
        ADDR_OUT_HI: out_r[63:32]  <= i_pwdata;
        default:     cyclic_r      <= cyclic_r;
      endcase
    end
  end

  // ==========================================================
  // exchange sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (start) st_nxt = ST_REQ;
      ST_REQ:  st_nxt = ST_WAIT;
      ST_WAIT: if (lnk.resp) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // latch image, request, capture answer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r    <= ST_IDLE;
      req_r   <= 1'b0;
      cmd_l_r <= '0;
      out_l_r <= '0;
      stat_r  <= '0;
      in_r    <= '0;
      ack_r   <= '0;
      done_r  <= 1'b0;
    end else if (i_ce) begin
      st_r  <= st_nxt;
      req_r <= st_r == ST_IDLE && start;
      if (st_r == ST_IDLE && start) begin
        cmd_l_r <= cmd_r;
        out_l_r <= out_r;
      end
      if (capture) begin
        stat_r <= lnk.stat;
        in_r   <= lnk.din;
        ack_r  <= ack_nxt;
      end
      done_r <= capture | (done_r & ~clr_done);
    end
  end

  assign lnk.req  = req_r;
  assign lnk.cmd  = cmd_l_r;
  assign lnk.dout = out_l_r;

endmodule // controller_end

// *** chan_link_chk.sv ***
// concurrent checks on the process image link between both ends
`timescale 1ns/1ps
module chan_link_chk import chan_pkg::*; (
  // clock and reset
  input wire logic             i_mclk,
  input wire logic             i_rst_n,
  // link signals
  input wire logic             req,
  input wire logic [CMD_W-1:0] cmd,
  input wire logic [DAT_W-1:0] dout,
  input wire logic             resp,
  input wire logic [CMD_W-1:0] stat,
  input wire logic [DAT_W-1:0] din
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // exchange timing and holding
  a_resp_after_req: assert property (req |=> resp)
    else $error("no answer one cycle after request");
  a_resp_has_cause: assert property (resp |-> $past(req))
    else $error("answer without request");
  a_req_spacing: assert property (req |=> !req [*2])
    else $error("requests closer than three cycles");
  a_stat_holds: assert property (
    !resp |-> $stable(stat) && $stable(din))
    else $error("condition or input data moved off answer");
  a_cmd_holds: assert property (
    !req |-> $stable(cmd) && $stable(dout))
    else $error("command or output data moved off request");
  // ==========================================================
  // per-channel condition byte contents
  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    a_mode_echo: assert property (
      resp |-> stat[8*c+7] == $past(cmd[8*c+7]))
      else $error("mode bit not acknowledged");
    a_num_echo: assert property (
      resp && $past(cmd[8*c+7]) |->
      stat[8*c+6 -: 7] == $past(cmd[8*c+6 -: 7]))
      else $error("register number not echoed");
    a_err_flag: assert property (
      resp && !$past(cmd[8*c+7]) |->
      stat[8*c+6] == (stat[8*c+1] | stat[8*c]))
      else $error("error flag disagrees with range flags");
  end
  // main scenarios
  c_reg_mode: cover property (resp && stat[7]);
  c_err_seen: cover property (resp && !stat[7] && stat[6]);
  c_two_xchg: cover property (req ##[3:40] req);
endmodule // chan_link_chk

// *** tb_top.sv ***
// self-checking bench for controller_end facing terminal_end
`timescale 1ns/1ps
module tb_top import chan_pkg::*;;
  // ==========================================================
  // signals
  logic              mclk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [DAT_W-1:0]  sample;
  logic [CH_N-1:0]   reg_mode;
  logic [31:0]       rd;
  logic [31:0]       fl;
  logic              err;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cycles = 0;
  int                nreq = 0;
  // ==========================================================
  // both ends joined by the link
  chan_link_if lnk();
  controller_end i_controller_end (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_ce(1'b1), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .lnk(lnk));
  terminal_end i_terminal_end (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_ce(1'b1), .i_sample(sample), .lnk(lnk), .o_reg_mode(reg_mode));
  chan_link_chk i_chan_link_chk (.i_mclk(mclk), .i_rst_n(rst_n),
    .req(lnk.req), .cmd(lnk.cmd), .dout(lnk.dout), .resp(lnk.resp),
    .stat(lnk.stat), .din(lnk.din));
  // ==========================================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      $display("mismatch at %0t: run timed out", $time);
      stop_test();
    end
  end
  // ==========================================================
  // tasks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one apb transfer, answer taken while pready stands high
  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // start one exchange, wait for done, keep flags, clear done
  task automatic xchg;
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    do apb(1'b0, ADDR_FLAGS, 32'h0); while (rd[FLAG_DONE_BIT] !== 1'b1);
    fl = rd;
    apb(1'b1, ADDR_FLAGS, 32'h0000_0002);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sample = 64'h0fff_0000_0800_1000;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // refused and plain accesses
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test access done");
    // process mode with reserved bits set, channel 1 over range
    apb(1'b1, ADDR_CMD, 32'h7f7f_7f7f);
    xchg();
    chk(fl, 32'h0000_003e);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h0000_0042);
    apb(1'b0, ADDR_IN_LO, 32'h0);
    chk(rd, 32'h0800_1000);
    apb(1'b0, ADDR_IN_HI, 32'h0);
    chk(rd, 32'h0fff_0000);
    chk({28'h0, reg_mode}, 32'h0);
    $display("test process done");
    // register mode: three writes and one read, all channels
    apb(1'b1, ADDR_CMD, 32'h95e3_d6e0);
    apb(1'b1, ADDR_OUT_LO, 32'h0900_c906);
    apb(1'b1, ADDR_OUT_HI, 32'h0000_0001);
    xchg();
    chk(fl, 32'h0000_003e);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h95e3_d6e0);
    apb(1'b0, ADDR_IN_LO, 32'h0);
    chk(rd, 32'h0900_c906);
    apb(1'b0, ADDR_IN_HI, 32'h0);
    chk(rd, 32'h0fff_0001);
    chk({28'h0, reg_mode}, 32'h0000_000f);
    $display("test register done");
    // back to process mode: thresholds and new under limit apply
    apb(1'b1, ADDR_CMD, 32'h0);
    xchg();
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h0000_416a);
    chk({28'h0, reg_mode}, 32'h0);
    $display("test limits done");
    // cyclic mode: one exchange every three cycles until stopped
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    nreq = 0;
    repeat (30) begin
      @(posedge mclk);
      if (lnk.req === 1'b1) begin
        nreq++;
      end
    end
    chk(nreq, 32'h0000_000a);
    apb(1'b1, ADDR_CTRL, 32'h0);
    do apb(1'b0, ADDR_FLAGS, 32'h0); while (rd[FLAG_BUSY_BIT] !== 1'b0);
    nreq = 0;
    repeat (6) begin
      @(posedge mclk);
      if (lnk.req === 1'b1) begin
        nreq++;
      end
    end
    chk(nreq, 32'h0);
    $display("test cyclic done");
    stop_test();
  end
endmodule // tb_top
